/* src/psc_strap_capture.sv */
/*
 * Power-on strap capture with pin turnaround, soft reset to machine check,
 * and the test-reset path of the scan port.
 * Assumes every pin input is asynchronous to clock and is synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none

module psc_strap_capture (
    input wire logic clock,
    input wire logic clk_en,
    input wire logic nrst,
    input wire logic hard_reset_n,
    input wire logic soft_reset_n,
    input wire logic [11:0] strap_pin_in,
    input wire logic [11:0] func_out,
    output logic [11:0] strap_pin_out,
    output logic [11:0] strap_pin_oe_n,
    output logic [11:0] pullup_en,
    output logic receiver_en,
    output psc_pkg::psc_straps_t straps,
    output logic serdes1_power_down,
    output logic serdes2_power_down,
    output logic machine_check,
    input wire logic tck,
    input wire logic tms,
    input wire logic trst_n,
    output logic tap_in_reset
);

    logic [1:0] hr_sync;
    logic [1:0] sr_sync;
    logic [11:0] pin_s1;
    logic [11:0] pin_s2;
    logic [1:0] tck_sync;
    logic [1:0] tms_sync;
    logic [1:0] trst_sync;
    logic sr_prev;
    logic tck_prev;
    logic [2:0] hold_cnt;
    logic [2:0] tms_cnt;
    psc_pkg::psc_state_t state;
    psc_pkg::psc_state_t next_state;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            hr_sync <= 2'h0;
            sr_sync <= 2'h3;
            pin_s1 <= 12'hFFF;
            pin_s2 <= 12'hFFF;
            tck_sync <= 2'h0;
            tms_sync <= 2'h3;
            trst_sync <= 2'h0;
        end else if (clk_en) begin
            hr_sync <= {hr_sync[0], hard_reset_n};
            sr_sync <= {sr_sync[0], soft_reset_n};
            pin_s1 <= strap_pin_in;
            pin_s2 <= pin_s1;
            tck_sync <= {tck_sync[0], tck};
            tms_sync <= {tms_sync[0], tms};
            trst_sync <= {trst_sync[0], trst_n};
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            psc_pkg::PSC_SAMPLE: begin
                if (hr_sync[1]) begin
                    next_state = psc_pkg::PSC_HOLD;
                end
            end
            psc_pkg::PSC_HOLD: begin
                if (!hr_sync[1]) begin
                    next_state = psc_pkg::PSC_SAMPLE;
                end else if (hold_cnt == psc_pkg::HOLD_CYCLES) begin
                    next_state = psc_pkg::PSC_RUN;
                end
            end
            psc_pkg::PSC_RUN: begin
                if (!hr_sync[1]) begin
                    next_state = psc_pkg::PSC_SAMPLE;
                end
            end
            default: next_state = psc_pkg::PSC_SAMPLE;
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state <= psc_pkg::PSC_SAMPLE;
            hold_cnt <= 3'h0;
        end else if (clk_en) begin
            state <= next_state;
            if (next_state == psc_pkg::PSC_HOLD) begin
                hold_cnt <= hold_cnt + 3'h1;
            end else begin
                hold_cnt <= 3'h0;
            end
        end
    end

    // The level sampled alongside the first high reset sample is taken on the release edge, so
    // anything the pins do after that cannot reach the captured word.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            straps <= psc_pkg::STRAP_RESET;
        end else if (clk_en) begin
            if (state == psc_pkg::PSC_SAMPLE && hr_sync[1]) begin
                straps <= pin_s2;
            end
        end
    end

    // The receiver and pull-up stay on through the hold window so the
    // capture sees settled levels; output drive starts on the same clock that both drop.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            strap_pin_oe_n <= 12'hFFF;
            strap_pin_out <= 12'h000;
            pullup_en <= psc_pkg::PULLUP_MASK;
            receiver_en <= 1'b1;
        end else if (clk_en) begin
            strap_pin_out <= func_out;
            if (next_state == psc_pkg::PSC_RUN) begin
                strap_pin_oe_n <= 12'h000;
                pullup_en <= 12'h000;
                receiver_en <= 1'b0;
            end else begin
                strap_pin_oe_n <= 12'hFFF;
                pullup_en <= psc_pkg::PULLUP_MASK;
                receiver_en <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            serdes1_power_down <= 1'b0;
            serdes2_power_down <= 1'b0;
        end else if (clk_en) begin
            serdes1_power_down <=
                straps.serdes1_cfg == psc_pkg::SERDES1_OFF_CODE;
            serdes2_power_down <= straps.serdes2_protocol_select ==
                psc_pkg::SERDES2_OFF_CODE;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sr_prev <= 1'b1;
            machine_check <= 1'b0;
        end else if (clk_en) begin
            sr_prev <= sr_sync[1];
            machine_check <= sr_prev && !sr_sync[1];
        end
    end

    // Five TMS-high clocks reach test reset from any controller state, so a
    // saturating count tracks that state without the full state machine.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            tck_prev <= 1'b0;
            tms_cnt <= psc_pkg::TAP_RESET_COUNT;
            tap_in_reset <= 1'b1;
        end else if (clk_en) begin
            tck_prev <= tck_sync[1];
            if (!trst_sync[1]) begin
                tms_cnt <= psc_pkg::TAP_RESET_COUNT;
                tap_in_reset <= 1'b1;
            end else if (tck_sync[1] && !tck_prev) begin
                if (!tms_sync[1]) begin
                    tms_cnt <= 3'h0;
                    tap_in_reset <= 1'b0;
                end else if (tms_cnt != psc_pkg::TAP_RESET_COUNT) begin
                    tms_cnt <= tms_cnt + 3'h1;
                    tap_in_reset <=
                        tms_cnt == psc_pkg::TAP_RESET_COUNT - 3'h1;
                end
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    no_drive_rst_a: assert property (
        clk_en && !hr_sync[1] |=> strap_pin_oe_n == 12'hFFF)
        else $error("strap pins driven during hard reset");
    latch_rel_a: assert property (
        clk_en && state == psc_pkg::PSC_SAMPLE && hr_sync[1]
        |=> straps == $past(pin_s2))
        else $error("straps not latched at release");
    drive_after_a: assert property (
        clk_en && $rose(hr_sync[1]) ##1 (clk_en && hr_sync[1])[*8]
        |-> strap_pin_oe_n == 12'h000)
        else $error("pins not returned to output use");
    pullup_recv_a: assert property (
        pullup_en != 12'h000 |-> receiver_en)
        else $error("pull-up on without receiver");
    pll_no_pull_a: assert property (pullup_en[5:0] == 6'h00)
        else $error("pull-up on a PLL ratio pin");
    straps_hold_a: assert property (
        state == psc_pkg::PSC_RUN && hr_sync[1] |=> $stable(straps))
        else $error("straps changed outside hard reset");
    sd1_down_a: assert property (
        clk_en |=> serdes1_power_down ==
        ($past(straps.serdes1_cfg) == psc_pkg::SERDES1_OFF_CODE))
        else $error("serdes1 power down wrong");
    sd2_down_a: assert property (
        clk_en |=> serdes2_power_down ==
        ($past(straps.serdes2_protocol_select) == psc_pkg::SERDES2_OFF_CODE))
        else $error("serdes2 power down wrong");
    mcheck_a: assert property (
        clk_en && sr_prev && !sr_sync[1] |=> machine_check)
        else $error("soft reset gave no machine check");
    tap_reset_a: assert property (
        tap_in_reset |-> tms_cnt == psc_pkg::TAP_RESET_COUNT)
        else $error("test reset without five TMS clocks");

    capture_c: cover property ($rose(hr_sync[1]) ##[1:20]
        state == psc_pkg::PSC_RUN);
    sd_off_c: cover property (serdes1_power_down && serdes2_power_down);
    mcheck_c: cover property (machine_check);
    tap_c: cover property (trst_sync[1] && $rose(tap_in_reset));

endmodule : psc_strap_capture

`default_nettype wire

/* src/psc_pkg.sv */
/*
 * Shared constants and types of the power-on strap capture block.
 * Assumes one platform clock and an active-low asynchronous reset.
 */
package psc_pkg;

    localparam int STRAP_W = 12;
    localparam int FIELD_W = 3;

    // Field positions inside the captured strap word.
    localparam int SERDES1_LSB = 9;
    localparam int SERDES2_LSB = 6;
    localparam int PLAT_PLL_LSB = 3;
    localparam int CORE_PLL_LSB = 0;

    // Encodings that power a SerDes block down; all ones is the default.
    localparam logic [2:0] SERDES1_OFF_CODE = 3'h6;
    localparam logic [2:0] SERDES2_OFF_CODE = 3'h6;

    // Value the capture register holds before any capture.
    localparam logic [11:0] STRAP_RESET = 12'hFFF;
    // Pins with an internal pull-up; the two PLL ratio fields have none.
    localparam logic [11:0] PULLUP_MASK = 12'hFC0;

    // Platform clocks the pull-up and receiver stay on after release.
    localparam logic [2:0] HOLD_CYCLES = 3'h4;
    // Consecutive TMS-high clocks that reach the test reset state.
    localparam logic [2:0] TAP_RESET_COUNT = 3'h5;

    typedef struct packed {
        logic [2:0] serdes1_cfg;
        logic [2:0] serdes2_protocol_select;
        logic [2:0] platform_pll_ratio;
        logic [2:0] core_pll_ratio;
    } psc_straps_t;

    typedef enum logic [1:0] {
        PSC_SAMPLE = 2'b00,
        PSC_HOLD = 2'b01,
        PSC_RUN = 2'b10
    } psc_state_t;

endpackage : psc_pkg

/* tb/psc_board_model.sv */
/*
 * Board model: strap resistors, the board drive on the PLL ratio pins,
 * and the debug probe with its reset merging.
 * Assumes the strap pins see the device's output, output enable and pull-up.
 */
`timescale 1ns/1ps
`default_nettype none
module psc_board_model (
    input wire logic [11:0] board_cfg,
    input wire logic [11:0] strap_pin_out,
    input wire logic [11:0] strap_pin_oe_n,
    input wire logic [11:0] pullup_en,
    input wire logic probe_hard_reset_n,
    input wire logic probe_trst,
    input wire logic sys_reset,
    output logic [11:0] strap_pin_in,
    output logic hard_reset_n,
    output logic trst_n
);
    // The probe hard reset is merged with sys_reset by logic; the probe test reset is a separate line.
    assign hard_reset_n = ~(probe_hard_reset_n | sys_reset);
    assign trst_n = ~probe_trst;
    always_comb begin
        for (int i = 0; i < 12; i++) begin
            if (!strap_pin_oe_n[i]) begin
                strap_pin_in[i] = strap_pin_out[i];
            end else if (i < 6) begin
                strap_pin_in[i] = board_cfg[i];
            end else if (!board_cfg[i]) begin
                strap_pin_in[i] = 1'b0;
            end else if (pullup_en[i]) begin
                strap_pin_in[i] = 1'b1;
            end else begin
                // A floating pin must not look like a stable level.
                strap_pin_in[i] = ~strap_pin_out[i];
            end
        end
    end
endmodule : psc_board_model
`default_nettype wire

/* tb/power_on_strap_capture_bench.sv */
/*
 * Self-checking bench for the strap capture block.
 * Assumes the board model above sits on the strap and reset pins.
 */
`timescale 1ns/1ps
`default_nettype none
module power_on_strap_capture_bench;
    logic clock = 1'b0, nrst = 1'b0, soft_reset_n = 1'b1, tck = 1'b0;
    logic tms = 1'b0, probe_hard_reset_n = 1'b1, probe_trst = 1'b1, sys_reset = 1'b0;
    logic [11:0] board_cfg = 12'hFFF, func_out = 12'h000;
    logic clk_en = 1'b1;
    // The three setups power down both, neither, then only SerDes 1.
    logic [11:0] cfg_list [3] = '{12'hDA9, 12'hFC3, 12'hDE5};
    wire logic [11:0] pin_in, pin_out, oe_n, pullup_en;
    wire logic receiver_en, sd1, sd2, mc, tap_in_reset, hard_reset_n, trst_n;
    psc_pkg::psc_straps_t straps;
    int mismatches = 0, check_count = 0, cycles = 0, n;
    always #10 clock = ~clock;
    psc_strap_capture dut_u (.clock(clock), .clk_en(clk_en), .nrst(nrst),
        .hard_reset_n(hard_reset_n), .soft_reset_n(soft_reset_n),
        .strap_pin_in(pin_in), .func_out(func_out), .strap_pin_out(pin_out),
        .strap_pin_oe_n(oe_n), .pullup_en(pullup_en),
        .receiver_en(receiver_en), .straps(straps),
        .serdes1_power_down(sd1), .serdes2_power_down(sd2),
        .machine_check(mc), .tck(tck), .tms(tms), .trst_n(trst_n),
        .tap_in_reset(tap_in_reset));
    psc_board_model board_u (.board_cfg(board_cfg), .strap_pin_out(pin_out),
        .strap_pin_oe_n(oe_n), .pullup_en(pullup_en),
        .probe_hard_reset_n(probe_hard_reset_n), .probe_trst(probe_trst),
        .sys_reset(sys_reset), .strap_pin_in(pin_in),
        .hard_reset_n(hard_reset_n), .trst_n(trst_n));
    task check(input logic [11:0] seen, input logic [11:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask : check
    task complete_run;
        $display("checks %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run
    // Checks land at the falling edge, clear of the registers' updates.
    task tick(input int k);
        repeat (k) @(posedge clock);
        @(negedge clock);
    endtask : tick
    // The scan clock runs at about a ninth of the platform clock.
    task tck_pulse(input logic m);
        @(posedge clock) tms <= m;
        tick(3);
        @(posedge clock) tck <= 1'b1;
        tick(3);
        @(posedge clock) tck <= 1'b0;
    endtask : tck_pulse
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            complete_run();
        end
    end
    initial begin
        tick(3);
        @(posedge clock) nrst <= 1'b1;
        tick(2);
        check({11'h0, tap_in_reset}, 12'h001);
        $display("reset test done");
        for (int k = 0; k < 3; k++) begin
            @(posedge clock);
            probe_hard_reset_n <= (k != 1);
            sys_reset <= (k == 1);
            board_cfg <= cfg_list[k];
            tick(6);
            check(oe_n, 12'hFFF);
            check(pullup_en, psc_pkg::PULLUP_MASK);
            @(posedge clock);
            probe_hard_reset_n <= 1'b0;
            sys_reset <= 1'b0;
            tick(4);
            check({11'h0, receiver_en}, 12'h001);
            check(straps, cfg_list[k]);
            @(posedge clock);
            board_cfg <= ~cfg_list[k];
            func_out <= 12'hA5A;
            tick(8);
            check(oe_n, 12'h000);
            check(pullup_en | {11'h0, receiver_en}, 12'h000);
            check(pin_out, 12'hA5A);
            check(straps, cfg_list[k]);
            check({10'h0, sd1, sd2}, {10'h0,
                cfg_list[k][11:9] == psc_pkg::SERDES1_OFF_CODE,
                cfg_list[k][8:6] == psc_pkg::SERDES2_OFF_CODE});
            $display("capture test %0d done", k);
        end
        @(posedge clock) soft_reset_n <= 1'b0;
        n = 0;
        while (mc !== 1'b1 && n < 10) begin
            @(negedge clock);
            n++;
        end
        check({11'h0, mc}, 12'h001);
        tick(1);
        check({11'h0, mc}, 12'h000);
        check(straps, cfg_list[2]);
        @(posedge clock) soft_reset_n <= 1'b1;
        $display("soft reset test done");
        @(posedge clock) probe_trst <= 1'b0;
        tck_pulse(1'b0);
        tick(4);
        check({11'h0, tap_in_reset}, 12'h000);
        repeat (5) tck_pulse(1'b1);
        tick(4);
        check({11'h0, tap_in_reset}, 12'h001);
        $display("scan reset test done");
        // With the enable low, neither a new hard reset nor new output data
        // may reach any register.
        @(posedge clock) clk_en <= 1'b0;
        probe_hard_reset_n <= 1'b1;
        func_out <= 12'h5A5;
        tick(6);
        check(oe_n, 12'h000);
        check(pin_out, 12'hA5A);
        check(straps, cfg_list[2]);
        $display("clock enable test done");
        complete_run();
    end
endmodule : power_on_strap_capture_bench
`default_nettype wire
